// *** rtl/mprb_pkg.sv ***
package mprb_pkg;

   // ****************************************
   // serial port
   // ****************************************
   localparam logic [6:0] DEV_ADDR = 7'h55;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] NV_OFFSET = 8'h40;
   localparam logic [7:0] REG_FIRST = 8'h4d;
   localparam logic [7:0] REG_LAST = 8'h56;
   localparam int NUM_REGS = 10;
   localparam logic [7:0] OFS_INTEGRAL_GAIN_AND_START_DELAY = 8'h4d;
   localparam logic [7:0] OFS_TACH_OUTPUT_CONTROL = 8'h4e;
   localparam logic [7:0] OFS_SOFT_RAMP_AND_DEADTIME = 8'h4f;
   localparam logic [7:0] OFS_OVERCURRENT_AND_BUFFER_CONFIG = 8'h50;
   localparam logic [7:0] OFS_SPEED_REQUEST = 8'h51;
   localparam logic [7:0] OFS_GATE_SLEW_AND_PULSE_THRESHOLD = 8'h52;
   localparam logic [7:0] OFS_SWITCH_CAPACITANCE_COMP = 8'h53;
   localparam logic [7:0] OFS_VOLTAGE_AND_SHUNT_RATING = 8'h54;
   localparam logic [7:0] OFS_STANDBY_AND_INPUT_THRESHOLD = 8'h55;
   localparam logic [7:0] OFS_RESPONSE_AND_RESTART_CONFIG = 8'h56;
   localparam logic [3:0] IDX_RATING = 4'h7;
   localparam int VOLT_LSB = 0;
   localparam int VOLT_MSB = 7;
   localparam int SHUNT_LSB = 8;
   localparam int SHUNT_MSB = 15;
   localparam logic [9:0][15:0] REG_RESET = {10{16'h0000}};

   // ****************************************
   // scaling
   // ****************************************
   localparam logic [15:0] VOLT_MV_PER_LSB = 16'h00c8;
   localparam logic [20:0] SPEED_MHZ_PER_LSB = 21'h0_0212;
   localparam logic [17:0] CUR_SCALE = 18'h0_007d;
   localparam logic [20:0] RES_MULT = 21'h0_0019;
   localparam int RES_SHIFT = 7;
   localparam int LAUNCH_SHIFT = 3;
   localparam logic [4:0] DIV_STEPS = 5'h12;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK = 3'h2,
      ST_RX = 3'h3,
      ST_TX = 3'h4,
      ST_TXACK = 3'h5,
      ST_WAIT = 3'h6
   } mprb_i2c_e;

   typedef struct packed {
      logic [9:0][15:0] word;
   } mprb_bank_s;

   typedef struct packed {
      logic [10:0] rated_speed_code;
      logic [10:0] rated_current_code;
      logic [2:0] launch_code;
      logic [7:0] resistance_code;
   } mprb_lower_s;

   typedef struct packed {
      logic [15:0] rated_voltage_mv;
      logic [20:0] rated_speed_mhz;
      logic [17:0] rated_current_ma;
      logic current_valid;
      logic [17:0] launch_current_ma;
      logic launch_valid;
      logic [13:0] resistance_mohm;
      logic shunt_zero;
   } mprb_scaled_s;

   typedef struct packed {
      logic busy;
      logic done;
      logic [4:0] cnt;
      logic [7:0] rem;
      logic [17:0] quot;
      logic [7:0] den;
   } mprb_div_s;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      mprb_i2c_e st;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic [1:0] phase;
      logic reading;
      logic [7:0] msb_hold;
      logic master_ack;
      logic sda_low;
      mprb_bank_s bank;
      mprb_scaled_s scaled;
      logic [17:0] div_num;
      logic [7:0] div_den;
      logic div_start;
   } mprb_state_s;

endpackage

// *** rtl/mprb_div.sv ***
`timescale 1ns/1ns
`default_nettype none

// restoring divider, one quotient bit per cycle
module mprb_div (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [17:0] num,
   input wire logic [7:0] den,
   output logic busy,
   output logic done,
   output logic [17:0] quot
);

   mprb_pkg::mprb_div_s r_reg;
   mprb_pkg::mprb_div_s r_next;

   always_comb begin
      logic [8:0] trial;
      trial = 9'h000;
      r_next = r_reg;
      r_next.done = 1'b0;
      if (start && !r_reg.busy) begin
         r_next.busy = 1'b1;
         r_next.cnt = mprb_pkg::DIV_STEPS;
         r_next.rem = 8'h00;
         r_next.quot = num;
         r_next.den = den;
      end else if (r_reg.busy) begin
         trial = {r_reg.rem, r_reg.quot[17]};
         r_next.quot = {r_reg.quot[16:0], 1'b0};
         // zero divisor always passes: quotient saturates to all ones
         if (trial >= {1'b0, r_reg.den}) begin
            r_next.rem = 8'(trial - {1'b0, r_reg.den});
            r_next.quot[0] = 1'b1;
         end else begin
            r_next.rem = trial[7:0];
         end
         r_next.cnt = r_reg.cnt - 5'h01;
         if (r_reg.cnt == 5'h01) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign busy = r_reg.busy;
   assign done = r_reg.done;
   assign quot = r_reg.quot;

endmodule

`default_nettype wire

// *** rtl/mprb_top.sv ***
// Notes on behaviour
// - rated voltage field [7:0] is unsigned and volts equal the field over 5.
// - rated speed in hertz equals the 11-bit rated speed field times 0.530.
// - rated current in milliamperes is the current field over (shunt field / 125).
// - launch current code zero means not applicable, else rated current times (code+1)/8.
// - resistance in ohms is resistance field over (V*4.096)/(shunt/125)/(V/10).
// - each register sits at its stored-word address plus 64, one bit per stored bit.
// - the device answers at 7-bit address 1010101; reads set the pointer, restart, and return two bytes.
`timescale 1ns/1ns
`default_nettype none

module mprb_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire mprb_pkg::mprb_lower_s lower,
   output var mprb_pkg::mprb_bank_s bank,
   output var mprb_pkg::mprb_scaled_s scaled
);

   mprb_pkg::mprb_state_s r_reg;
   mprb_pkg::mprb_state_s r_next;

   // ****************************************
   // bus conditions
   // ****************************************
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic in_range;
   logic [3:0] idx;
   logic [15:0] rd_word;
   logic [7:0] tx_byte;
   logic div_busy;
   logic div_done;
   logic [17:0] div_quot;
   logic [7:0] volt_code;
   logic [7:0] shunt_code;

   // only stages two and three are looked at
   assign scl_rise = r_reg.scl_s2 & ~r_reg.scl_s3;
   assign scl_fall = ~r_reg.scl_s2 & r_reg.scl_s3;
   assign start_cond = r_reg.scl_s2 & r_reg.scl_s3 & ~r_reg.sda_s2 & r_reg.sda_s3;
   assign stop_cond = r_reg.scl_s2 & r_reg.scl_s3 & r_reg.sda_s2 & ~r_reg.sda_s3;

   // ****************************************
   // register decode
   // ****************************************
   assign in_range = (r_reg.ptr >= mprb_pkg::REG_FIRST) && (r_reg.ptr <= mprb_pkg::REG_LAST);
   assign idx = 4'(r_reg.ptr - mprb_pkg::REG_FIRST);
   assign rd_word = in_range ? r_reg.bank.word[idx] : 16'h0000;
   assign tx_byte = (r_reg.phase == 2'h0) ? rd_word[15:8] : rd_word[7:0];
   assign volt_code = r_reg.bank.word[mprb_pkg::IDX_RATING][mprb_pkg::VOLT_MSB:mprb_pkg::VOLT_LSB];
   assign shunt_code = r_reg.bank.word[mprb_pkg::IDX_RATING][mprb_pkg::SHUNT_MSB:mprb_pkg::SHUNT_LSB];

   mprb_div u_div (
      .clk(clk),
      .rst(rst),
      .start(r_reg.div_start),
      .num(r_reg.div_num),
      .den(r_reg.div_den),
      .busy(div_busy),
      .done(div_done),
      .quot(div_quot)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic load_tx;
      logic [17:0] cur_num;
      logic [21:0] launch_prod;
      logic [20:0] res_prod;
      load_tx = 1'b0;
      cur_num = 18'(lower.rated_current_code) * mprb_pkg::CUR_SCALE;
      launch_prod = 22'(r_reg.scaled.rated_current_ma) * 22'({1'b0, lower.launch_code} + 4'h1);
      res_prod = 21'(lower.resistance_code) * 21'(shunt_code) * mprb_pkg::RES_MULT;
      r_next = r_reg;
      r_next.div_start = 1'b0;
      r_next.scl_s1 = scl_in;
      r_next.scl_s2 = r_reg.scl_s1;
      r_next.scl_s3 = r_reg.scl_s2;
      r_next.sda_s1 = sda_in;
      r_next.sda_s2 = r_reg.sda_s1;
      r_next.sda_s3 = r_reg.sda_s2;

      if (stop_cond) begin
         r_next.st = mprb_pkg::ST_IDLE;
         r_next.sda_low = 1'b0;
      end else if (start_cond) begin
         // a repeated start lands here too and keeps the pointer
         r_next.st = mprb_pkg::ST_ADDR;
         r_next.bitcnt = 4'h0;
         r_next.sda_low = 1'b0;
      end else begin
         unique case (r_reg.st)
            mprb_pkg::ST_IDLE, mprb_pkg::ST_WAIT: begin
               r_next.sda_low = 1'b0;
            end
            mprb_pkg::ST_ADDR, mprb_pkg::ST_RX: begin
               if (scl_rise) begin
                  r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
                  r_next.bitcnt = r_reg.bitcnt + 4'h1;
               end else if (scl_fall && r_reg.bitcnt == mprb_pkg::BITS_PER_BYTE) begin
                  r_next.bitcnt = 4'h0;
                  if (r_reg.st == mprb_pkg::ST_ADDR) begin
                     if (r_reg.shift[7:1] == mprb_pkg::DEV_ADDR) begin
                        r_next.reading = r_reg.shift[0];
                        r_next.phase = 2'h0;
                        r_next.sda_low = 1'b1;
                        r_next.st = mprb_pkg::ST_ACK;
                     end else begin
                        r_next.st = mprb_pkg::ST_WAIT;
                     end
                  end else begin
                     r_next.sda_low = 1'b1;
                     r_next.st = mprb_pkg::ST_ACK;
                     unique case (r_reg.phase)
                        2'h0: begin
                           r_next.ptr = r_reg.shift;
                           r_next.phase = 2'h1;
                        end
                        2'h1: begin
                           r_next.msb_hold = r_reg.shift;
                           r_next.phase = 2'h2;
                        end
                        2'h2: begin
                           // out-of-range words are acknowledged but dropped
                           if (in_range) begin
                              r_next.bank.word[idx] = {r_reg.msb_hold, r_reg.shift};
                           end
                           r_next.ptr = r_reg.ptr + 8'h01;
                           r_next.phase = 2'h1;
                        end
                        default: begin
                           r_next.phase = 2'h0;
                        end
                     endcase
                  end
               end
            end
            mprb_pkg::ST_ACK: begin
               if (scl_fall) begin
                  if (r_reg.reading) begin
                     load_tx = 1'b1;
                  end else begin
                     r_next.sda_low = 1'b0;
                     r_next.st = mprb_pkg::ST_RX;
                  end
               end
            end
            mprb_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (r_reg.bitcnt == mprb_pkg::LAST_BIT) begin
                     r_next.sda_low = 1'b0;
                     r_next.bitcnt = 4'h0;
                     r_next.st = mprb_pkg::ST_TXACK;
                  end else begin
                     r_next.shift = {r_reg.shift[6:0], 1'b0};
                     r_next.sda_low = ~r_reg.shift[6];
                     r_next.bitcnt = r_reg.bitcnt + 4'h1;
                  end
               end
            end
            mprb_pkg::ST_TXACK: begin
               if (scl_rise) begin
                  r_next.master_ack = ~r_reg.sda_s2;
               end else if (scl_fall) begin
                  if (r_reg.master_ack) begin
                     load_tx = 1'b1;
                  end else begin
                     r_next.st = mprb_pkg::ST_WAIT;
                  end
               end
            end
            default: begin
               r_next.st = mprb_pkg::ST_IDLE;
            end
         endcase
      end

      // high byte first, pointer steps after the low byte
      if (load_tx) begin
         r_next.st = mprb_pkg::ST_TX;
         r_next.shift = tx_byte;
         r_next.sda_low = ~tx_byte[7];
         r_next.bitcnt = 4'h0;
         if (r_reg.phase == 2'h0) begin
            r_next.phase = 2'h1;
         end else begin
            r_next.phase = 2'h0;
            r_next.ptr = r_reg.ptr + 8'h01;
         end
      end

      // ****************************************
      // scaled parameters
      // ****************************************
      r_next.scaled.rated_voltage_mv = 16'(volt_code) * mprb_pkg::VOLT_MV_PER_LSB;
      r_next.scaled.rated_speed_mhz = 21'(lower.rated_speed_code) * mprb_pkg::SPEED_MHZ_PER_LSB;
      // voltage cancels out of the resistance formula, leaving r*s*1000/5120
      r_next.scaled.resistance_mohm = res_prod[20:mprb_pkg::RES_SHIFT];
      r_next.scaled.shunt_zero = (shunt_code == 8'h00);
      r_next.scaled.launch_valid = (lower.launch_code != 3'h0);
      r_next.scaled.launch_current_ma = (lower.launch_code != 3'h0) ?
         launch_prod[17 + mprb_pkg::LAUNCH_SHIFT:mprb_pkg::LAUNCH_SHIFT] : 18'h0_0000;
      // a division takes 18 cycles, so it reruns only when its operands move
      if (!div_busy && !r_reg.div_start && {cur_num, shunt_code} != {r_reg.div_num, r_reg.div_den}) begin
         r_next.div_num = cur_num;
         r_next.div_den = shunt_code;
         r_next.div_start = 1'b1;
         r_next.scaled.current_valid = 1'b0;
      end
      if (div_done) begin
         r_next.scaled.rated_current_ma = div_quot;
         r_next.scaled.current_valid = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
         r_reg.scl_s1 <= 1'b1;
         r_reg.scl_s2 <= 1'b1;
         r_reg.scl_s3 <= 1'b1;
         r_reg.sda_s1 <= 1'b1;
         r_reg.sda_s2 <= 1'b1;
         r_reg.sda_s3 <= 1'b1;
         r_reg.bank <= mprb_pkg::REG_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = r_reg.sda_low;
   assign bank = r_reg.bank;
   assign scaled = r_reg.scaled;

endmodule

`default_nettype wire

// *** test/mprb_chk_sva.sv ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// port checker
// ****************************************
module mprb_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire mprb_pkg::mprb_lower_s lower,
   input wire mprb_pkg::mprb_bank_s bank,
   input wire mprb_pkg::mprb_scaled_s scaled
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] sh;
   assign sh = bank.word[7][15:8];

   AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
      else $error("sda_out driven high");
   // data may only move while the clock line is low
   AST_SDA_MOVES_LOW: assert property (($rose(sda_oe) || $fell(sda_oe)) |-> !scl_in)
      else $error("sda changed with scl high");
   AST_VOLT: assert property (!$past(rst) |-> scaled.rated_voltage_mv == 16'($past(bank.word[7][7:0]) * 16'h00c8))
      else $error("rated voltage wrong");
   AST_SPEED: assert property (!$past(rst) |->
      scaled.rated_speed_mhz == 21'(21'($past(lower.rated_speed_code)) * 21'h0_0212))
      else $error("rated speed wrong");
   AST_CUR: assert property ($rose(scaled.current_valid) && $stable(lower.rated_current_code) && $stable(sh) |->
      scaled.rated_current_ma == ((sh == 8'h00) ? 18'h3_ffff :
      18'(32'(lower.rated_current_code) * 32'h0000_007d / 32'(sh))))
      else $error("rated current wrong");
   AST_DIV_BOUND: assert property ($fell(scaled.current_valid) |-> ##[1:40] scaled.current_valid)
      else $error("divide too slow");
   AST_LAUNCH_VALID: assert property (!$past(rst) |-> scaled.launch_valid == ($past(lower.launch_code) != 3'h0))
      else $error("launch valid wrong");
   AST_LAUNCH: assert property (!$past(rst) |-> scaled.launch_current_ma == (($past(lower.launch_code) == 3'h0) ?
      18'h0_0000 : 18'((36'($past(scaled.rated_current_ma)) * (36'($past(lower.launch_code)) + 36'h1)) >> 3)))
      else $error("launch current wrong");
   AST_RES: assert property (!$past(rst) |-> scaled.resistance_mohm ==
      14'((32'($past(lower.resistance_code)) * 32'($past(sh)) * 32'h0000_0019) >> 7))
      else $error("resistance wrong");
   AST_SHUNT_ZERO: assert property (!$past(rst) |-> scaled.shunt_zero == ($past(sh) == 8'h00))
      else $error("shunt zero flag wrong");
endmodule

bind mprb_top mprb_chk mprb_chk_i (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .lower(lower), .bank(bank), .scaled(scaled));

`default_nettype wire

// *** test/mprb_host.sv ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// serial host model
// ****************************************
module mprb_host (
   input wire logic clk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic drv = 1'b1;
   initial scl = 1'b1;
   // pull-up: a released line reads high
   assign sda = drv & ~sda_oe;
   // six cycles per phase keeps above the four-cycle minimum
   task automatic half();
      repeat (6) @(negedge clk);
   endtask
   task automatic start();
      half();
      drv = 1'b1;
      half();
      scl = 1'b1;
      half();
      drv = 1'b0;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      half();
      drv = 1'b0;
      half();
      scl = 1'b1;
      half();
      drv = 1'b1;
      half();
   endtask
   // eight data bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
      for (int i = 8; i >= 0; i--) begin
         half();
         drv = (i == 0) ? a : d[i-1];
         half();
         scl = 1'b1;
         half();
         if (i == 0) r = sda; else q[i-1] = sda;
         scl = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// testbench
// ****************************************
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire logic scl;
   wire logic sda;
   logic sda_out;
   logic sda_oe;
   mprb_pkg::mprb_lower_s lower = '0;
   mprb_pkg::mprb_bank_s bank;
   mprb_pkg::mprb_scaled_s scaled;
   int num_errors = 0;
   int n_checks = 0;
   logic [7:0] q;
   logic [15:0] w;
   logic [31:0] cur;
   logic ack;
   // address, written word, word expected back; last row is outside the map
   logic [39:0] rows [11] = '{40'h4d_a5a5_a5a5, 40'h4e_5a5a_5a5a, 40'h4f_ffff_ffff, 40'h50_0001_0001,
      40'h51_8000_8000, 40'h52_1357_1357, 40'h53_2468_2468, 40'h54_1937_1937, 40'h55_fedc_fedc,
      40'h56_0f0f_0f0f, 40'h57_abcd_0000};

   mprb_top mprb_top_i (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .lower(lower), .bank(bank), .scaled(scaled));
   mprb_host mprb_host_i (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task automatic snd(input logic [7:0] d);
      mprb_host_i.xfer(d, 1'b1, q, ack);
      chk(ack, 1'b0, "byte not acknowledged");
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      mprb_host_i.start();
      snd(8'haa);
      snd(a);
      snd(d[15:8]);
      snd(d[7:0]);
      mprb_host_i.stop();
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      mprb_host_i.start();
      snd(8'haa);
      snd(a);
      mprb_host_i.start();
      snd(8'hab);
      mprb_host_i.xfer(8'hff, 1'b0, d[15:8], ack);
      mprb_host_i.xfer(8'hff, 1'b1, d[7:0], ack);
      mprb_host_i.stop();
   endtask

   initial begin
      // about 18k cycles expected; the 50k-cycle limit stays well under the 100k-cycle budget
      #1000000;
      num_errors++;
      end_of_test();
   end

   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 10; i++) chk(bank.word[i], 16'h0000, "reset value");
      for (int i = 0; i < 11; i++) begin
         wr(rows[i][39:32], rows[i][31:16]);
         if (i < 10) chk(bank.word[i], rows[i][15:0], "bank word");
         rd(rows[i][39:32], w);
         chk(w, rows[i][15:0], "read back");
      end
      $display("register map test done");
      // foreign address must be ignored
      mprb_host_i.start();
      mprb_host_i.xfer(8'ha8, 1'b1, q, ack);
      chk(ack, 1'b1, "foreign address acknowledged");
      mprb_host_i.stop();
      $display("address test done");
      lower.rated_speed_code = 11'h7ff;
      lower.rated_current_code = 11'h4d2;
      lower.resistance_code = 8'hc8;
      repeat (40) @(negedge clk);
      cur = 32'h0000_04d2 * 32'h0000_007d / 32'h0000_0019;
      chk(scaled.rated_voltage_mv, 32'h0000_0037 * 32'h0000_00c8, "voltage");
      chk(scaled.rated_speed_mhz, 32'h0000_07ff * 32'h0000_0212, "speed");
      chk(scaled.rated_current_ma, cur, "current");
      chk(scaled.current_valid, 1'b1, "current valid");
      chk(scaled.resistance_mohm, (32'h0000_00c8 * 32'h0000_0019 * 32'h0000_0019) >> 7, "resistance");
      for (int c = 0; c < 8; c++) begin
         lower.launch_code = 3'(c);
         repeat (4) @(negedge clk);
         chk(scaled.launch_current_ma, (c == 0) ? 32'h0000_0000 : (cur * (c + 1)) >> 3, "launch");
         chk(scaled.launch_valid, (c != 0), "launch valid");
      end
      $display("scaling test done");
      wr(8'h54, 16'h0037);
      repeat (40) @(negedge clk);
      chk(scaled.shunt_zero, 1'b1, "shunt zero");
      chk(scaled.rated_current_ma, 18'h3_ffff, "saturated current");
      $display("zero shunt test done");
      // second reset in mid-run must clear the bank and release the data line
      rst = 1'b1;
      repeat (2) @(negedge clk);
      chk(scaled.current_valid, 1'b0, "valid in reset");
      rst = 1'b0;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 10; i++) chk(bank.word[i], 16'h0000, "reset again");
      chk(sda_oe, 1'b0, "sda released");
      $display("reset test done");
      end_of_test();
   end
endmodule

`default_nettype wire
